// ---- logic/pcu_card_pins.sv ----
// Card pin behaviour: host decode, attribute memory, modem pins, reset filter
// Function
// - Host service request low when service needed; acts as ready/busy before init.
// - Subsystem interrupt goes high after a host attribute-memory write to an even address inside the configuration block.
// - Host gate low reads memory; card drives host data only while gated or during an I/O read strobe.
// - Each user output pin is active low, driven by its control bit.
// - User outputs inactive on reset, in loop mode, or with bit cleared.
// - Receiver timing comes from the receiver clock at sixteen times baud.
// - Subsystem read pin is read enable or data strobe by bus mode.
// - Select low: gate/write enable mean attribute, I/O strobes mean I/O space.
// - Common memory accesses get no response; only attribute and I/O decode.
// - Master reset clears serial core and returns card to unconfigured state.
// - Status bit 6 shows the present ring indicator state.
// - Status bit 2 sets on ring indicator low-to-high since last status read.
// - Ring trailing edge with status interrupt enabled raises an interrupt.
// - Qualified active-low reset output on an open-drain pin.
// - Request-to-send active when its control bit is set.
// - Request-to-send inactive on reset, loop mode, or control bit 1 clear.
// - Separate-bus select picks separate address pins or multiplexed shared bus.
// - Ninth address pin extends the subsystem address to nine bits.
// - Reset output follows inverted master reset after eight stable arbitration clocks.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module pcu_card_pins (
  input  wire logic             ref_clk,                // 100 MHz system clock
  input  wire logic             rst_n,                  // Synchronous reset
  input  wire logic             master_reset,           // Raw master reset pin
  input  wire logic             arbitration_clock,      // Reset filter clock, sampled
  input  wire logic             rcvr_clk_16x,           // Receiver clock, sampled
  input  wire pcu_pkg::pcu_host_t host,                 // Host bus pins
  output logic [7:0]            host_data_o,            // Host read data
  output logic                  host_data_oe_n,         // Low while card drives host data
  output logic                  host_service_request_n, // Service request / ready-busy
  input  wire pcu_pkg::pcu_sub_t sub,                   // Subsystem bus pins
  output logic [7:0]            subsys_shared_bus_o,    // Subsystem read data
  output logic                  subsys_shared_bus_oe_n, // Low while card drives shared bus
  output logic                  subsys_irq,             // Subsystem interrupt
  input  wire logic             ring_indicator_n,       // Ring indicator pin
  output logic                  request_to_send_n,      // Request-to-send
  output logic                  user_output_a_o,        // Open-drain level, always low
  output logic                  user_output_a_oe_n,     // Low pulls user output A low
  output logic                  user_output_b_o,        // Open-drain level, always low
  output logic                  user_output_b_oe_n,     // Low pulls user output B low
  output logic                  reset_out_o,            // Open-drain level, always low
  output logic                  reset_out_oe_n,         // Low pulls reset output low
  output logic                  rx_bit_tick,            // One pulse per receive bit time
  input  wire logic [3:0]       reg_addr,               // Register address
  input  wire logic [7:0]       reg_wdata,              // Register write data
  input  wire logic             reg_wr,                 // Register write strobe
  input  wire logic             reg_rd,                 // Register read strobe
  output logic [7:0]            reg_rdata               // Read data, cycle after strobe
);

  logic [7:0] mem [0:pcu_pkg::ATTR_WORDS-1];
  logic       filt_q, arb_prev_q, rclk_prev_q, ri_prev_q;
  logic [2:0] filt_cnt_q;
  logic [3:0] baud_cnt_q;
  logic       tick_q;
  logic [7:0] mcr_q, ier_q;
  logic       ring_trailing_edge_flag_q, ready_q, hwr_q;
  logic       gate_prev_q, we_prev_q, io_read_strobe_n_prev_q, io_write_strobe_n_prev_q;
  logic       srd_prev_q, swr_prev_q;
  logic [7:0] sub_lat_q, host_dq, sub_dq, rdata_q;
  logic       clr, loop, ri_eff_n, ring_trailing_edge_flag_rise, msr_rd;
  logic       attr_rd, attr_wr, io_rd, io_wr, attr_wr_go, io_wr_go;
  logic       sub_rd, sub_wr, sub_wr_go;
  logic [8:0] host_idx, sub_idx;
  logic [7:0] modem_status_reg, io_sel;

  // Attribute index is valid only below the end of the configuration block
  function automatic logic idx_ok(input logic [8:0] idx);
    idx_ok = (idx < pcu_pkg::ATTR_LIMIT);
  endfunction

  // Shared read mux for the serial registers seen from host I/O and reg port
  function automatic logic [7:0] io_read(input logic [2:0] off, input logic [7:0] m,
                                         input logic [7:0] c, input logic [7:0] e);
    if (off == pcu_pkg::IO_MCR) begin
      io_read = c;
    end else if (off == pcu_pkg::IO_MSR) begin
      io_read = m;
    end else if (off == pcu_pkg::IO_IER) begin
      io_read = e;
    end else begin
      io_read = 8'h00;
    end
  endfunction

  // Core clear: local reset or the qualified master reset
  assign clr  = !rst_n || filt_q;
  assign loop = mcr_q[pcu_pkg::MCR_LOOP];

  // Reset filter: count arbitration-clock rises while the input differs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      arb_prev_q <= 1'b0;
    end else begin
      arb_prev_q <= arbitration_clock;
    end
  end

  // Bounce back to the held level restarts the count
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      filt_q     <= 1'b1;
      filt_cnt_q <= 3'h0;
    end else if (master_reset == filt_q) begin
      filt_cnt_q <= 3'h0;
    end else if (arbitration_clock && !arb_prev_q) begin
      if (filt_cnt_q == pcu_pkg::FILT_LAST) begin
        filt_q     <= master_reset;
        filt_cnt_q <= 3'h0;
      end else begin
        filt_cnt_q <= filt_cnt_q + 3'h1;
      end
    end
  end

  // Qualified reset pin: pulled low while the filtered reset is high
  assign reset_out_o    = 1'b0;
  assign reset_out_oe_n = !filt_q;

  // Receiver bit timing from the sampled 16x clock
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      rclk_prev_q <= 1'b0;
      baud_cnt_q  <= 4'h0;
      tick_q      <= 1'b0;
    end else begin
      rclk_prev_q <= rcvr_clk_16x;
      tick_q      <= 1'b0;
      if (rcvr_clk_16x && !rclk_prev_q) begin
        baud_cnt_q <= baud_cnt_q + 4'h1;
        tick_q     <= (baud_cnt_q == pcu_pkg::BAUD_LAST);
      end
    end
  end
  assign rx_bit_tick = tick_q;

  // Host decode; common memory (select high) never qualifies
  assign attr_rd = !host.ce_n && !host.attr_n && !host.gate_n && !host.addr[0];
  assign attr_wr = !host.ce_n && !host.attr_n && !host.we_n && !host.addr[0];
  assign io_rd   = !host.ce_n && !host.attr_n && !host.io_read_strobe_n_n;
  assign io_wr   = !host.ce_n && !host.attr_n && !host.io_write_strobe_n_n;
  assign host_idx   = host.addr[9:1];
  assign attr_wr_go = attr_wr && we_prev_q && idx_ok(host_idx);
  assign io_wr_go   = io_wr && io_write_strobe_n_prev_q;

  // Subsystem strobes differ by bus mode
  assign sub_rd = sub.ds_mode ? (!sub.rd_n && sub.wr_n) : !sub.rd_n;
  assign sub_wr = sub.ds_mode ? (!sub.rd_n && !sub.wr_n) : !sub.wr_n;
  assign sub_idx   = {sub.a8, sub.sep_sel ? sub.a_low : sub_lat_q};
  assign sub_wr_go = sub_wr && swr_prev_q && idx_ok(sub_idx);

  // Strobe history; writes act once, on the strobe's first active cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gate_prev_q <= 1'b0;
      we_prev_q   <= 1'b1;
      io_read_strobe_n_prev_q <= 1'b0;
      io_write_strobe_n_prev_q <= 1'b1;
      srd_prev_q  <= 1'b0;
      swr_prev_q  <= 1'b1;
    end else begin
      gate_prev_q <= attr_rd;
      we_prev_q   <= !attr_wr;
      io_read_strobe_n_prev_q <= io_rd;
      io_write_strobe_n_prev_q <= !io_wr;
      srd_prev_q  <= sub_rd;
      swr_prev_q  <= !sub_wr;
    end
  end

  // Multiplexed mode: address is caught while no strobe is active
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sub_lat_q <= 8'h00;
    end else if (!sub.sep_sel && !sub_rd && !sub_wr) begin
      sub_lat_q <= sub.bus;
    end
  end

  // Attribute memory; a host write wins if both sides strike together
  always_ff @(posedge ref_clk) begin
    if (attr_wr_go) begin
      mem[host_idx] <= host.data;
    end else if (sub_wr_go) begin
      mem[sub_idx] <= sub.bus;
    end
  end

  // Ring indicator as seen by the core; loop mode feeds it from output A
  assign ri_eff_n  = loop ? !mcr_q[pcu_pkg::MCR_OUTA] : ring_indicator_n;
  assign ring_trailing_edge_flag_rise = ri_eff_n && !ri_prev_q;
  assign modem_status_reg       = {1'b0, !ri_eff_n, 3'b000, ring_trailing_edge_flag_q, 2'b00};
  assign msr_rd    = (reg_rd && reg_addr == pcu_pkg::REG_MSR) ||
                     (!io_rd && io_read_strobe_n_prev_q && host.addr[2:0] == pcu_pkg::IO_MSR);

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      ri_prev_q <= 1'b1;
    end else begin
      ri_prev_q <= ri_eff_n;
    end
  end

  // Trailing-edge flag: a new edge wins over the clearing read
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      ring_trailing_edge_flag_q <= 1'b0;
    end else if (ring_trailing_edge_flag_rise) begin
      ring_trailing_edge_flag_q <= 1'b1;
    end else if (msr_rd) begin
      ring_trailing_edge_flag_q <= 1'b0;
    end
  end

  // Modem control and interrupt enable, from host I/O or the register port
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      mcr_q <= pcu_pkg::MCR_RST;
      ier_q <= pcu_pkg::IER_RST;
    end else if (io_wr_go && host.addr[2:0] == pcu_pkg::IO_MCR) begin
      mcr_q <= host.data;
    end else if (io_wr_go && host.addr[2:0] == pcu_pkg::IO_IER) begin
      ier_q <= host.data;
    end else if (reg_wr && reg_addr == pcu_pkg::REG_MCR) begin
      mcr_q <= reg_wdata;
    end else if (reg_wr && reg_addr == pcu_pkg::REG_IER) begin
      ier_q <= reg_wdata;
    end
  end

  // Modem outputs: loop mode holds them inactive whatever the bits say
  assign user_output_a_o    = 1'b0;
  assign user_output_b_o    = 1'b0;
  assign user_output_a_oe_n = !(mcr_q[pcu_pkg::MCR_OUTA] && !loop && !filt_q);
  assign user_output_b_oe_n = !(mcr_q[pcu_pkg::MCR_OUTB] && !loop && !filt_q);
  assign request_to_send_n  = !(mcr_q[pcu_pkg::MCR_RTS] && !loop && !filt_q);

  // Card readiness and the host-write flag; hardware set beats software clear
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      ready_q <= 1'b0;
      hwr_q   <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == pcu_pkg::REG_CTRL) begin
        ready_q <= reg_wdata[pcu_pkg::CTRL_RDY];
      end
      if (attr_wr_go) begin
        hwr_q <= 1'b1;
      end else if (reg_wr && reg_addr == pcu_pkg::REG_CTRL && reg_wdata[pcu_pkg::CTRL_HWR]) begin
        hwr_q <= 1'b0;
      end
    end
  end
  assign subsys_irq = hwr_q;

  // Busy (low) until the subsystem declares ready, then the interrupt
  localparam int IER_MS_IDX = pcu_pkg::IER_MS;
  assign host_service_request_n = ready_q ?
                                  !(ring_trailing_edge_flag_q && ier_q[IER_MS_IDX]) : 1'b0;

  // Read data registers; host memory reads go out only under the gate
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      host_dq <= 8'h00;
      sub_dq  <= 8'h00;
      rdata_q <= 8'h00;
    end else begin
      if (attr_rd) begin
        host_dq <= idx_ok(host_idx) ? mem[host_idx] : 8'hFF;
      end else begin
        host_dq <= io_read(host.addr[2:0], modem_status_reg, mcr_q, ier_q);
      end
      sub_dq <= idx_ok(sub_idx) ? mem[sub_idx] : 8'hFF;
      if (reg_rd && reg_addr == pcu_pkg::REG_CTRL) begin
        rdata_q <= {6'h00, hwr_q, ready_q};
      end else if (reg_rd) begin
        rdata_q <= io_read(reg_addr[2:0], modem_status_reg, mcr_q, ier_q);
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign host_data_o            = host_dq;
  assign host_data_oe_n         = !((attr_rd && gate_prev_q) || (io_rd && io_read_strobe_n_prev_q));
  assign subsys_shared_bus_o    = sub_dq;
  assign subsys_shared_bus_oe_n = !(sub_rd && srd_prev_q);
  assign reg_rdata              = rdata_q;

  // Checks
  a_filter_eight: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(filt_q) |-> $past(filt_cnt_q) == pcu_pkg::FILT_LAST)
    else $error("reset output changed before eight stable clocks");
  a_reset_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reset_out_oe_n == !filt_q)
    else $error("reset pin not the inverse of filtered reset");
  a_ring_trailing_edge_flag_sets: assert property (@(posedge ref_clk) disable iff (clr)
    (ring_trailing_edge_flag_rise && !filt_q) |=> ring_trailing_edge_flag_q || filt_q)
    else $error("trailing edge not flagged");
  a_ring_trailing_edge_flag_clears: assert property (@(posedge ref_clk) disable iff (clr)
    (msr_rd && !ring_trailing_edge_flag_rise) ##1 !clr |-> !ring_trailing_edge_flag_q)
    else $error("trailing flag survived status read");
  a_gate_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !host_data_oe_n |-> !host.attr_n && !host.ce_n && (!host.gate_n || !host.io_read_strobe_n_n))
    else $error("host data driven without gate");
  a_attr_irq: assert property (@(posedge ref_clk) disable iff (clr)
    attr_wr_go ##1 !clr |-> subsys_irq)
    else $error("host attribute write gave no subsystem interrupt");
  a_loop_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    loop |-> request_to_send_n && user_output_a_oe_n && user_output_b_oe_n)
    else $error("modem output active in loop mode");
  a_mcr_cleared: assert property (@(posedge ref_clk) disable iff (!rst_n)
    filt_q |=> mcr_q == pcu_pkg::MCR_RST)
    else $error("control bits not cleared by master reset");
  a_busy_early: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(ready_q) |-> !host_service_request_n)
    else $error("not busy while unconfigured");
  a_ms_intr: assert property (@(posedge ref_clk) disable iff (clr)
    (ready_q && ier_q[IER_MS_IDX] && ring_trailing_edge_flag_rise) |=> !host_service_request_n || clr)
    else $error("ring edge gave no interrupt");
  a_baud_tick: assert property (@(posedge ref_clk) disable iff (clr)
    rx_bit_tick |-> $past(baud_cnt_q) == pcu_pkg::BAUD_LAST)
    else $error("bit tick not on sixteenth edge");

  c_filter_release: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(filt_q));
  c_attr_write:     cover property (@(posedge ref_clk) disable iff (clr) attr_wr_go);
  c_ring_intr:      cover property (@(posedge ref_clk) disable iff (clr)
    ready_q && $fell(host_service_request_n));
  c_sub_read:       cover property (@(posedge ref_clk) disable iff (clr)
    !subsys_shared_bus_oe_n && !sub.sep_sel);

endmodule // pcu_card_pins

// ---- logic/pcu_pkg.sv ----
// Shared constants and carrier types for the card pin-behaviour block
package pcu_pkg;
  // Register port offsets
  localparam logic [3:0] REG_IER  = 4'h1;
  localparam logic [3:0] REG_MCR  = 4'h4;
  localparam logic [3:0] REG_MSR  = 4'h6;
  localparam logic [3:0] REG_CTRL = 4'h8;
  // Modem control, interrupt enable and status bit positions
  localparam int MCR_RTS  = 1;
  localparam int MCR_OUTA = 2;
  localparam int MCR_OUTB = 3;
  localparam int MCR_LOOP = 4;
  localparam int IER_MS   = 3;
  localparam int MSR_RING_TRAILING_EDGE_FLAG = 2;
  localparam int MSR_RI   = 6;
  localparam int CTRL_RDY = 0;
  localparam int CTRL_HWR = 1;
  // Values after reset
  localparam logic [7:0] MCR_RST  = 8'h00;
  localparam logic [7:0] IER_RST  = 8'h00;
  // Counts of cycles or edges
  localparam logic [2:0] FILT_LAST = 3'h7;   // eighth arbitration edge
  localparam logic [3:0] BAUD_LAST = 4'hF;   // sixteenth receiver-clock edge
  // Attribute memory layout, in half-address words
  localparam int          ATTR_WORDS = 264;
  localparam logic [8:0]  ATTR_LIMIT = 9'h108;
  // Host I/O offsets of the serial registers
  localparam logic [2:0]  IO_IER = 3'h1;
  localparam logic [2:0]  IO_MCR = 3'h4;
  localparam logic [2:0]  IO_MSR = 3'h6;

  // Host card-bus strobes and address, all sampled on ref_clk
  typedef struct packed {
    logic       ce_n;     // Card enable
    logic       attr_n;   // Attribute/I-O select
    logic       gate_n;   // Attribute read gate
    logic       we_n;     // Attribute write enable
    logic       io_read_strobe_n_n;   // I/O read strobe
    logic       io_write_strobe_n_n;   // I/O write strobe
    logic [9:0] addr;     // Host address
    logic [7:0] data;     // Host write data
  } pcu_host_t;

  // Subsystem microcontroller bus
  typedef struct packed {
    logic       sep_sel;  // Separate address/data when high
    logic       ds_mode;  // Data-strobe mode when high
    logic       rd_n;     // Read enable or data strobe
    logic       wr_n;     // Write enable or read/write
    logic       a8;       // Ninth address bit
    logic [7:0] a_low;    // Low address pins
    logic [7:0] bus;      // Shared bus, input side
  } pcu_sub_t;
endpackage

// ---- bench/pcu_host_model.sv ----
// Card-bus host controller model driving the block's host strobes
`timescale 1ns/1ns
module pcu_host_model (
  input  wire logic         ref_clk, // System clock
  output pcu_pkg::pcu_host_t host,   // Card bus toward the block
  input  wire logic [7:0]   rd_data, // Card read data
  input  wire logic         rd_oe_n  // Low while card drives data
);
  // Idle bus: no card enable, common memory, all strobes high
  initial host = {6'h3F, 10'h000, 8'hFF};

  // One access; oe returns the enable during the strobe and just after it
  task automatic xfer(input logic io, wr, com, input logic [9:0] a,
                      input logic [7:0] d, output logic [7:0] q, output logic [1:0] oe);
    @(posedge ref_clk);
    host.ce_n   <= 1'b0;
    host.attr_n <= com;                // Low selects attribute or I/O space
    host.addr   <= a;
    host.data   <= wr ? d : ~d;        // Not a stale copy while reading
    host.we_n   <= !(wr && !io);
    host.io_write_strobe_n_n <= !(wr && io);
    host.gate_n <= !(!wr && !io);      // Gate low to read memory
    host.io_read_strobe_n_n <= !(!wr && io);
    repeat (2) @(posedge ref_clk);
    #1 q = rd_data;
    oe[1] = rd_oe_n;
    @(posedge ref_clk);
    host <= {6'h3F, a, ~host.data};    // Release, data flips so no old value lingers
    #1 oe[0] = rd_oe_n;
    @(posedge ref_clk);
  endtask
endmodule // pcu_host_model

// ---- bench/pcu_card_pins_test.sv ----
// Self-checking bench for the card pin-behaviour block
`timescale 1ns/1ns
module pcu_card_pins_test;
  logic ref_clk, rst_n, master_reset, arbitration_clock, rcvr_clk_16x, ring_indicator_n;
  logic host_data_oe_n, host_service_request_n, subsys_shared_bus_oe_n, subsys_irq;
  logic request_to_send_n, user_output_a_o, user_output_a_oe_n, user_output_b_o;
  logic user_output_b_oe_n, reset_out_o, reset_out_oe_n, rx_bit_tick, reg_wr, reg_rd;
  logic [7:0] host_data_o, subsys_shared_bus_o, reg_wdata, reg_rdata;
  logic [3:0] reg_addr;
  pcu_pkg::pcu_host_t host;
  pcu_pkg::pcu_sub_t  sub;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int ticks = 0;

  pcu_card_pins dut (.ref_clk, .rst_n, .master_reset, .arbitration_clock, .rcvr_clk_16x,
    .host, .host_data_o, .host_data_oe_n, .host_service_request_n, .sub,
    .subsys_shared_bus_o, .subsys_shared_bus_oe_n, .subsys_irq, .ring_indicator_n,
    .request_to_send_n, .user_output_a_o, .user_output_a_oe_n, .user_output_b_o,
    .user_output_b_oe_n, .reset_out_o, .reset_out_oe_n, .rx_bit_tick, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  pcu_host_model hm (.ref_clk, .host, .rd_data(host_data_o), .rd_oe_n(host_data_oe_n));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    ticks <= ticks + (rx_bit_tick === 1'b1);
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Register port master: one-cycle strobes, read data in the next cycle only
  task automatic reg_wr_t(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_rd_t(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Move master reset to lvl, then count arbitration rises across the filter
  task automatic t_filter(input logic lvl);
    @(posedge ref_clk);
    master_reset <= lvl;
    repeat (7) begin
      @(posedge ref_clk);
      arbitration_clock <= 1'b1;
      repeat (2) @(posedge ref_clk);
      arbitration_clock <= 1'b0;
      if (cyc < 0) break;
    end
    settle(3);
    chk("rst_out_7", {7'h0, lvl}, {7'h0, reset_out_oe_n});
    @(posedge ref_clk);
    arbitration_clock <= 1'b1;
    repeat (2) @(posedge ref_clk);
    arbitration_clock <= 1'b0;
    settle(3);
    chk("rst_out_8", {7'h0, !lvl}, {7'h0, reset_out_oe_n});
    chk("modem_pins", 8'h07, {5'h0, request_to_send_n, user_output_a_oe_n,
        user_output_b_oe_n});
    chk("busy", 8'h00, {7'h0, host_service_request_n});
    chk("od_levels", 8'h00, {5'h0, reset_out_o, user_output_a_o, user_output_b_o});
    $display("filter test done, level %0b", lvl);
  endtask

  task automatic t_rx();
    int t0;
    t0 = ticks;
    repeat (32) begin
      @(posedge ref_clk);
      rcvr_clk_16x <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rcvr_clk_16x <= 1'b0;
    end
    settle(4);
    chk("rx_ticks", 8'h02, 8'(ticks - t0));
    $display("receiver clock test done");
  endtask

  // Every control bit alone, all together, loop mode, then cleared
  task automatic t_mcr();
    logic [7:0] mv[6] = '{8'h02, 8'h04, 8'h08, 8'h0E, 8'h1E, 8'h00};
    logic [2:0] ex[6] = '{3'b011, 3'b101, 3'b110, 3'b000, 3'b111, 3'b111};
    logic [7:0] d;
    reg_wr_t(pcu_pkg::REG_CTRL, 8'h01);
    settle(1);
    chk("ready", 8'h01, {7'h0, host_service_request_n});
    foreach (mv[i]) begin
      reg_wr_t(pcu_pkg::REG_MCR, mv[i]);
      settle(1);
      chk("mcr_pins", {5'h0, ex[i]}, {5'h0, request_to_send_n, user_output_a_oe_n,
          user_output_b_oe_n});
    end
    reg_rd_t(4'hF, d);
    chk("unmapped", 8'h00, d);
    $display("modem control test done");
  endtask

  // Falling then rising ring edge, interrupt disabled then enabled
  task automatic t_ring();
    logic [7:0] d;
    reg_rd_t(pcu_pkg::REG_MSR, d);
    for (int i = 0; i < 2; i++) begin
      reg_wr_t(pcu_pkg::REG_IER, i ? 8'h08 : 8'h00);
      @(posedge ref_clk);
      ring_indicator_n <= 1'b0;
      settle(3);
      chk("req_ri_low", 8'h01, {7'h0, host_service_request_n});
      reg_rd_t(pcu_pkg::REG_MSR, d);
      chk("msr_ri_low", 8'h40, d & 8'h44);
      @(posedge ref_clk);
      ring_indicator_n <= 1'b1;
      settle(3);
      chk("req_ring_trailing_edge_flag", {7'h0, i == 0}, {7'h0, host_service_request_n});
      reg_rd_t(pcu_pkg::REG_MSR, d);
      chk("msr_ring_trailing_edge_flag", 8'h04, d & 8'h44);
      reg_rd_t(pcu_pkg::REG_MSR, d);
      chk("msr_clear", 8'h00, d & 8'h44);
    end
    settle(1);
    chk("req_idle", 8'h01, {7'h0, host_service_request_n});
    $display("ring test done");
  endtask

  task automatic t_host();
    logic [7:0] d;
    logic [1:0] oe;
    hm.xfer(1'b0, 1'b1, 1'b0, 10'h200, 8'h5A, d, oe);
    chk("sub_irq", 8'h01, {7'h0, subsys_irq});
    reg_wr_t(pcu_pkg::REG_CTRL, 8'h03);
    hm.xfer(1'b0, 1'b1, 1'b1, 10'h200, 8'hA5, d, oe);
    chk("irq_common", 8'h00, {7'h0, subsys_irq});
    hm.xfer(1'b0, 1'b0, 1'b1, 10'h200, 8'h00, d, oe);
    chk("common_oe_n", 8'h03, {6'h0, oe});
    hm.xfer(1'b0, 1'b0, 1'b0, 10'h200, 8'h00, d, oe);
    chk("attr_read", 8'h5A, d);
    chk("attr_oe_n", 8'h01, {6'h0, oe});
    hm.xfer(1'b1, 1'b1, 1'b0, 10'h004, 8'h0E, d, oe);
    chk("io_mcr_pins", 8'h00, {5'h0, request_to_send_n, user_output_a_oe_n,
        user_output_b_oe_n});
    hm.xfer(1'b1, 1'b0, 1'b0, 10'h004, 8'h00, d, oe);
    chk("io_mcr_read", 8'h0E, d);
    $display("host bus test done");
  endtask

  // Separate strobes, data strobe, then multiplexed address on the shared bus
  task automatic t_sub();
    logic [1:0] md[3] = '{2'b10, 2'b11, 2'b00};
    foreach (md[i]) begin
      @(posedge ref_clk);
      sub.sep_sel <= md[i][1];
      sub.ds_mode <= md[i][0];
      sub.a8 <= 1'b1;
      sub.a_low <= md[i][1] ? 8'h00 : 8'hFF;
      sub.bus <= md[i][1] ? 8'hFF : 8'h00;
      @(posedge ref_clk);
      sub.rd_n <= 1'b0;
      sub.bus <= 8'hFF;
      repeat (2) @(posedge ref_clk);
      #1 chk("sub_read", 8'h5A, subsys_shared_bus_oe_n ? 8'hEE : subsys_shared_bus_o);
      @(posedge ref_clk);
      sub.rd_n <= 1'b1;
      settle(1);
      chk("sub_oe_idle", 8'h01, {7'h0, subsys_shared_bus_oe_n});
    end
    // Subsystem write on separate buses, then read it back
    @(posedge ref_clk);
    sub.sep_sel <= 1'b1;
    sub.ds_mode <= 1'b0;
    sub.a_low <= 8'h01;
    sub.bus <= 8'h3C;
    @(posedge ref_clk);
    sub.wr_n <= 1'b0;
    @(posedge ref_clk);
    sub.wr_n <= 1'b1;
    @(posedge ref_clk);
    sub.rd_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("sub_write", 8'h3C, subsys_shared_bus_o);
    @(posedge ref_clk);
    sub.rd_n <= 1'b1;
    $display("subsystem bus test done");
  endtask

  // Main sequence
  initial begin
    logic [7:0] d;
    rst_n = 1'b0;
    master_reset = 1'b1;
    arbitration_clock = 1'b0;
    rcvr_clk_16x = 1'b0;
    ring_indicator_n = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sub = {5'b00110, 16'h0000}; // Separate bus off, strobes idle
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_filter(1'b0);
    t_rx();
    t_mcr();
    t_ring();
    t_host();
    t_sub();
    t_filter(1'b1);
    t_filter(1'b0);
    reg_rd_t(pcu_pkg::REG_MCR, d);
    chk("mcr_after_reset", 8'h00, d);
    test_done();
  end
endmodule // pcu_card_pins_test
